/* File: rtl/mspc_top.sv */
// Mode strap capture, power-down gating and clock path control
//
// Function
// [RL1] Capture all straps at reset pin release
// [RL2] Rx power-down high gates ADC clock, bias
// [RL3] Power-down sleeps fast-waking analog blocks of path
// [RL4] Tx power-down high gates DAC clocks, bias
// [RL5] PLL keeps running unless serial setting stops
// [RL6] Half duplex select low: Tx gated, port drives
// [RL7] Half duplex select high: Rx gated, port input
// [RL8] Select gating keeps analog on unless powered down
// [RL9] Select acts only in half duplex
// [RL10] Capture economy strap: high saves ADC power
// [RL11] Capture duplex strap; low means half duplex
// [RL12] Half duplex width strap: low parallel, high interleaved
// [RL13] Capture chip-select: low disables serial, straps active
// [RL14] Strap-only systems keep serial enable low
// [RL15] Serial off: straps pick interpolation and PLL factor
// [RL16] Two clock paths from one reference
// [RL17] PLL pre-divide 1/5, multiply 1..16
// [RL18] Rx divider 1, 2 or 4, independent
// [RL19] Alternative timing lets PLL clock Rx ADCs
// [RL20] Captured straps hold until next reset
// [RL21] Interpolation code map fixed, fourth reserved
`default_nettype none
module mspc_top
    import mspc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Board pins, all asynchronous to the reference clock
    input wire logic i_reset_n_pin,
    input wire logic i_rx_path_powerdown_pin,
    input wire logic i_tx_path_powerdown_pin,
    input wire logic i_transmit_receive_select,
    input wire logic i_adc_economy_strap,
    input wire logic i_serial_out_shared_pin,
    input wire logic i_interface_pin_two,
    input wire logic i_spi_cs_pin,
    input wire logic i_serial_data_io_pin,
    input wire logic i_serial_clk_pin,
    // Serial-side settings, same clock, used only with the serial port on
    input wire logic i_spi_pll_off,
    input wire logic i_spi_prediv_sel,
    input wire logic [2:0] i_spi_mul_sel,
    input wire logic [1:0] i_spi_rxdiv_sel,
    input wire logic i_spi_alt_timing,
    // Captured configuration and control outputs, all registered
    output logic o_config_valid,
    output logic o_adc_economy,
    output logic o_half_duplex,
    output logic o_interleaved,
    output logic o_spi_enabled,
    output logic [1:0] o_interp_code,
    output logic o_interp_reserved,
    output logic o_pll_prediv5,
    output logic [4:0] o_pll_mul,
    output logic o_pll_run,
    output logic o_rx_sleep,
    output logic o_tx_sleep,
    output logic o_rx_clk_en,
    output logic o_tx_clk_en,
    output logic o_rx_bias_en,
    output logic o_tx_bias_en,
    output logic o_port_drive,
    output logic o_rx_clk_tick,
    output logic o_rx_from_pll
);

    // =========================================================
    // Pin synchronisers: three stages, change taken once 2 and 3 agree
    // =========================================================
    localparam int NPIN = 10;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_q, s2_q, s3_q, flt_q;
    logic [NPIN-1:0] flt_d;
    assign pin_raw = {i_reset_n_pin, i_rx_path_powerdown_pin, i_tx_path_powerdown_pin,
                      i_transmit_receive_select, i_adc_economy_strap,
                      i_serial_out_shared_pin, i_interface_pin_two, i_spi_cs_pin,
                      i_serial_data_io_pin, i_serial_clk_pin};
    // Straps share the reset pin's path, so both reach the capture edge
    // with one delay and a strap that settles with the reset pin is safe
    // Filtered level only moves when the two later stages agree
    assign flt_d = (s2_q & s3_q) | (flt_q & (s2_q | s3_q));

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            flt_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
        end
    end

    // Synchronised and filtered pin levels
    wire logic rstn_s = flt_q[9];
    wire logic rxpd_s = flt_q[8];
    wire logic txpd_s = flt_q[7];
    wire logic trsel_s = flt_q[6];
    wire logic econ_s = flt_q[5];
    wire logic duplex_s = flt_q[4];
    wire logic width_s = flt_q[3];
    wire logic cs_s = flt_q[2];
    wire logic interp_lo_s = flt_q[1];
    wire logic interp_hi_s = flt_q[0];

    // =========================================================
    // Strap capture on reset pin rising edge
    // =========================================================
    mspc_state_type state_q, state_d;
    logic rstn_prev_q;
    wire logic rstn_rise = rstn_s & ~rstn_prev_q;

    // Capture only on the release edge; straps ignored afterwards
    always_comb begin
        state_d = state_q;
        case (state_q)
            MSPC_IN_RESET: if (rstn_rise) state_d = MSPC_CAPTURE; // [RL1]
            MSPC_CAPTURE: state_d = MSPC_RUN;
            MSPC_RUN: if (!rstn_s) state_d = MSPC_IN_RESET; // [RL20]
            default: state_d = MSPC_IN_RESET;
        endcase
    end

    // Load strobe: one edge per release, none while running
    wire logic take = (state_q == MSPC_IN_RESET) && rstn_rise;

    logic econ_q, fullduplex_q, width_q, cs_q;
    logic [1:0] interp_q;

    // Sequencer and release edge detector
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= MSPC_IN_RESET;
            rstn_prev_q <= MSPC_RST_BIT;
        end else begin
            state_q <= state_d;
            rstn_prev_q <= rstn_s;
        end
    end

    // Strap latches load once, then ignore the pins until the next release
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            econ_q <= MSPC_RST_BIT;
            fullduplex_q <= MSPC_RST_BIT;
            width_q <= MSPC_RST_BIT;
            cs_q <= MSPC_RST_BIT;
            interp_q <= MSPC_RST_INTERP;
        end else if (take) begin // [RL1] [RL20]
            econ_q <= econ_s; // [RL10]
            fullduplex_q <= duplex_s; // [RL11]
            width_q <= width_s; // [RL12]
            cs_q <= cs_s; // [RL13]
            interp_q <= {interp_hi_s, interp_lo_s}; // [RL15]
        end
    end

    // =========================================================
    // Decoding of the captured configuration
    // =========================================================
    // Half duplex is the low strap; chip-select high hands pins to serial
    wire logic cfg_run = (state_q == MSPC_RUN);
    wire logic hd = ~fullduplex_q; // [RL11]
    wire logic spi_on = cs_q; // [RL13]
    // Interpolation factor meaningful only while straps own the pins
    wire logic interp_rsv = ~spi_on && (interp_q == MSPC_INTERP_RSV); // [RL21]

    // PLL multiply: straps when serial is off, else serial setting
    logic [4:0] mul_val;
    always_comb begin
        mul_val = 5'h01;
        if (!spi_on) begin
            case (interp_q) // [RL15] [RL21]
                MSPC_INTERP_1X: mul_val = 5'h01;
                MSPC_INTERP_2X: mul_val = 5'h02;
                MSPC_INTERP_4X: mul_val = 5'h04;
                default: mul_val = 5'h01; // Reserved falls back to 1x
            endcase
        end else begin
            case (i_spi_mul_sel) // [RL17]
                MSPC_MUL_1: mul_val = 5'h01;
                MSPC_MUL_2: mul_val = 5'h02;
                MSPC_MUL_4: mul_val = 5'h04;
                MSPC_MUL_8: mul_val = 5'h08;
                MSPC_MUL_16: mul_val = 5'h10;
                default: mul_val = 5'h01;
            endcase
        end
    end
    // Pre-divide of five exists only through the serial port
    wire logic prediv5 = spi_on && (i_spi_prediv_sel == MSPC_PREDIV_5); // [RL17]

    // =========================================================
    // Power-down and direction gating
    // =========================================================
    // Select acts only once straps are live and in half duplex; in full
    // duplex each direction keeps its own clock and the port stays split
    wire logic sel_active = cfg_run && hd; // [RL9]
    wire logic rx_clk_on = ~rxpd_s && ~(sel_active && trsel_s); // [RL2] [RL7]
    wire logic tx_clk_on = ~txpd_s && ~(sel_active && ~trsel_s); // [RL4] [RL6]
    // Analog follows only the power-down pins, never the select
    wire logic rx_sleep = rxpd_s; // [RL3] [RL8]
    wire logic tx_sleep = txpd_s; // [RL3] [RL8]
    // PLL survives Tx gating so the output clock keeps going
    wire logic pll_on = ~(spi_on && i_spi_pll_off); // [RL5]
    // Port drives only for Rx in half duplex; full duplex splits the bus
    wire logic drive = sel_active && ~trsel_s; // [RL6] [RL7]

    // =========================================================
    // Rx clock path divider, independent of the PLL
    // =========================================================
    logic [1:0] rxdiv_q;
    logic [1:0] rxdiv_sel;
    assign rxdiv_sel = spi_on ? i_spi_rxdiv_sel : MSPC_RXDIV_1; // [RL18]
    logic tick_d;
    // Tick select reads the Rx path count; code three means no divide
    always_comb begin
        case (rxdiv_sel) // [RL16] [RL18]
            MSPC_RXDIV_2: tick_d = rxdiv_q[MSPC_RXDIV_BIT2];
            MSPC_RXDIV_4: tick_d = &rxdiv_q[MSPC_RXDIV_BIT4:MSPC_RXDIV_BIT2];
            default: tick_d = 1'h1;
        endcase
    end
    // Rx clock path counts only while its digital clock is enabled
    wire logic rx_run = cfg_run && rx_clk_on;
    wire logic alt_t = spi_on && i_spi_alt_timing; // [RL19]

    // =========================================================
    // Output registers
    // =========================================================
    // Count restarts while the Rx clock is gated, so the first tick
    // after wake-up comes a full divide period later
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rxdiv_q <= '0;
            o_rx_clk_tick <= MSPC_RST_BIT;
            o_rx_from_pll <= MSPC_RST_BIT;
        end else begin
            rxdiv_q <= rx_run ? rxdiv_q + 2'h1 : '0; // [RL18]
            o_rx_clk_tick <= rx_run && tick_d; // [RL16] [RL18]
            o_rx_from_pll <= alt_t && pll_on; // [RL19]
        end
    end

    // Captured configuration, frozen between reset pin releases
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_config_valid <= MSPC_RST_BIT;
            o_adc_economy <= MSPC_RST_BIT;
            o_half_duplex <= MSPC_RST_BIT;
            o_interleaved <= MSPC_RST_BIT;
            o_spi_enabled <= MSPC_RST_BIT;
            o_interp_code <= MSPC_RST_INTERP;
            o_interp_reserved <= MSPC_RST_BIT;
        end else begin
            o_config_valid <= cfg_run;
            o_adc_economy <= econ_q; // [RL10]
            o_half_duplex <= hd; // [RL11]
            o_interleaved <= hd && width_q; // [RL12]
            o_spi_enabled <= spi_on; // [RL13]
            o_interp_code <= interp_q; // [RL15]
            o_interp_reserved <= interp_rsv; // [RL21]
        end
    end

    // PLL settings; the run flag ignores every Tx gate on purpose
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_pll_prediv5 <= MSPC_RST_BIT;
            o_pll_mul <= 5'h01;
            o_pll_run <= MSPC_RST_BIT;
        end else begin
            o_pll_prediv5 <= prediv5; // [RL17]
            o_pll_mul <= mul_val; // [RL15] [RL17]
            o_pll_run <= cfg_run && pll_on; // [RL5]
        end
    end

    // Power and direction; reset leaves both paths asleep, port released
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rx_sleep <= 1'h1;
            o_tx_sleep <= 1'h1;
            o_rx_clk_en <= MSPC_RST_BIT;
            o_tx_clk_en <= MSPC_RST_BIT;
            o_rx_bias_en <= MSPC_RST_BIT;
            o_tx_bias_en <= MSPC_RST_BIT;
            o_port_drive <= MSPC_RST_BIT;
        end else begin
            o_rx_sleep <= rx_sleep; // [RL3]
            o_tx_sleep <= tx_sleep; // [RL3]
            o_rx_clk_en <= rx_run; // [RL2] [RL7]
            o_tx_clk_en <= cfg_run && tx_clk_on; // [RL4] [RL6]
            o_rx_bias_en <= ~rxpd_s; // [RL2] [RL8]
            o_tx_bias_en <= ~txpd_s; // [RL4] [RL8]
            o_port_drive <= drive; // [RL6] [RL7]
        end
    end

endmodule : mspc_top
`default_nettype wire

/* File: rtl/mspc_pkg.sv */
// Package of constants and types for the mode strap power and clock control block
`default_nettype none
package mspc_pkg;
    // Interpolation strap codes {high, low}
    localparam logic [1:0] MSPC_INTERP_1X = 2'h0;
    localparam logic [1:0] MSPC_INTERP_2X = 2'h1;
    localparam logic [1:0] MSPC_INTERP_4X = 2'h2;
    localparam logic [1:0] MSPC_INTERP_RSV = 2'h3;
    // PLL pre-divide select codes
    localparam logic MSPC_PREDIV_1 = 1'h0;
    localparam logic MSPC_PREDIV_5 = 1'h1;
    // PLL multiply select codes
    localparam logic [2:0] MSPC_MUL_1 = 3'h0;
    localparam logic [2:0] MSPC_MUL_2 = 3'h1;
    localparam logic [2:0] MSPC_MUL_4 = 3'h2;
    localparam logic [2:0] MSPC_MUL_8 = 3'h3;
    localparam logic [2:0] MSPC_MUL_16 = 3'h4;
    // Rx divider select codes
    localparam logic [1:0] MSPC_RXDIV_1 = 2'h0;
    localparam logic [1:0] MSPC_RXDIV_2 = 2'h1;
    localparam logic [1:0] MSPC_RXDIV_4 = 2'h2;
    // Rx divider counter bits that give divide by two and by four
    localparam int MSPC_RXDIV_BIT2 = 0;
    localparam int MSPC_RXDIV_BIT4 = 1;
    // Power-up time bound for blocks that sleep with a path
    localparam int MSPC_FAST_WAKE_US = 10;
    localparam int MSPC_CLK_MHZ = 25;
    localparam int MSPC_FAST_WAKE_CYC = MSPC_FAST_WAKE_US * MSPC_CLK_MHZ;
    // Economy power saving in percent
    localparam int MSPC_ADC_SAVE_PCT = 40;
    // Reset values of the captured configuration
    localparam logic MSPC_RST_BIT = 1'h0;
    localparam logic [1:0] MSPC_RST_INTERP = 2'h0;
    // Strap capture states
    typedef enum logic [1:0] {
        MSPC_IN_RESET,
        MSPC_CAPTURE,
        MSPC_RUN
    } mspc_state_type;
endpackage : mspc_pkg
`default_nettype wire

/* File: test/mspc_chk.sv */
// Checker of strap capture, gating and clock control outputs
`default_nettype none
module mspc_chk (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_reset_n_pin,
    input wire logic o_config_valid,
    input wire logic o_adc_economy,
    input wire logic o_half_duplex,
    input wire logic o_interleaved,
    input wire logic o_spi_enabled,
    input wire logic [1:0] o_interp_code,
    input wire logic [4:0] o_pll_mul,
    input wire logic o_pll_run,
    input wire logic o_rx_sleep,
    input wire logic o_tx_sleep,
    input wire logic o_rx_clk_en,
    input wire logic o_tx_clk_en,
    input wire logic o_rx_bias_en,
    input wire logic o_tx_bias_en,
    input wire logic o_port_drive,
    input wire logic o_rx_clk_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // ==========================================
    // Capture sequence: pin released and held
    sequence pin_release;
        $rose(i_reset_n_pin) ##1 (i_reset_n_pin && !i_rst)[*8];
    endsequence
    sequence cfg_settled;
        o_config_valid && $past(o_config_valid);
    endsequence
    capture_done_a: assert property (pin_release |-> o_config_valid)
        else $error("config not valid after reset pin release");
    strap_hold_a: assert property (cfg_settled |-> $stable({o_adc_economy, o_half_duplex,
        o_interleaved, o_spi_enabled, o_interp_code}))
        else $error("captured straps changed while running");
    rx_sleep_a: assert property (o_rx_sleep |-> !o_rx_clk_en && !o_rx_bias_en)
        else $error("rx asleep but clock or bias on");
    tx_sleep_a: assert property (o_tx_sleep |-> !o_tx_clk_en && !o_tx_bias_en)
        else $error("tx asleep but clock or bias on");
    bias_keep_a: assert property (o_config_valid |->
        o_rx_bias_en == !o_rx_sleep && o_tx_bias_en == !o_tx_sleep)
        else $error("bias enable not tied to power down");
    port_drive_a: assert property (o_port_drive |->
        o_half_duplex && o_config_valid && !o_tx_clk_en)
        else $error("port driving outside half duplex receive");
    rx_gate_a: assert property (o_config_valid && o_half_duplex && !o_port_drive
        |-> !o_rx_clk_en)
        else $error("rx clock on in half duplex transmit");
    width_mode_a: assert property (o_interleaved |-> o_half_duplex)
        else $error("interleaved outside half duplex");
    pll_keep_a: assert property (o_config_valid && !o_spi_enabled |-> o_pll_run)
        else $error("pll stopped in strap mode");
    strap_mul_a: assert property (o_config_valid && !o_spi_enabled |-> o_pll_mul ==
        (o_interp_code == 2'h3 ? 5'h01 : 5'h01 << o_interp_code))
        else $error("pll factor differs from interpolation straps");
    rx_tick_gate_a: assert property (o_rx_clk_tick |-> o_rx_clk_en && o_config_valid)
        else $error("rx tick while rx clock gated");
    rx_div_one_a: assert property (o_rx_clk_en && !o_spi_enabled |-> o_rx_clk_tick)
        else $error("rx tick missing in strap mode");
endmodule : mspc_chk
bind mspc_top mspc_chk u_chk (.*);
`default_nettype wire

/* File: test/mspc_host.sv */
// Board strap and host model driving reset pin and mode straps
`default_nettype none
module mspc_host (
    input wire logic i_ref_clk,
    input wire logic i_rel,
    input wire logic [5:0] i_cfg,
    output logic o_reset_n_pin,
    output logic [5:0] o_straps
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    logic [5:0] pins_q;
    // Straps held around release, then reused pins toggle every cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rel) begin
            cnt_q <= 4'h0;
            pins_q <= i_cfg;
        end else if (cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end else begin
            pins_q <= {~pins_q[5:3], pins_q[2], ~pins_q[1:0]};
        end
    end
    assign o_reset_n_pin = i_rel;
    assign o_straps = pins_q;
endmodule : mspc_host
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench of the strap capture and power control block
`default_nettype none
`define CHK(n, e, s) comparisons++; if ((s) !== (e)) begin n_fail++; \
    $display("FAIL %s exp %h got %h", n, e, s); end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, rel = 1'b0, samp = 1'b0;
    logic rxpd = 1'b0, txpd = 1'b0, sel = 1'b0, poff = 1'b0, pdiv = 1'b0, alt = 1'b0;
    logic [2:0] mul = 3'h0;
    logic [1:0] rxdiv = 2'h0;
    logic [5:0] cfg = 6'h00, st;
    logic rn, win = 1'h0, tchk = 1'h0;
    wire logic tick;
    wire logic [22:0] seen;
    logic [22:0] exp_v;
    logic [22:0] q[$];
    int qt[$];
    int n_fail = 0, comparisons = 0, seed, n_tick = 0, exp_t;
    always #20 clk = ~clk;
    // ==========================================
    // Partner and design
    mspc_host host (.i_ref_clk(clk), .i_rel(rel), .i_cfg(cfg), .o_reset_n_pin(rn),
        .o_straps(st));
    mspc_top dut (.i_ref_clk(clk), .i_rst(rst), .i_reset_n_pin(rn),
        .i_rx_path_powerdown_pin(rxpd), .i_tx_path_powerdown_pin(txpd),
        .i_transmit_receive_select(sel), .i_adc_economy_strap(st[5]),
        .i_serial_out_shared_pin(st[4]), .i_interface_pin_two(st[3]),
        .i_spi_cs_pin(st[2]), .i_serial_clk_pin(st[1]), .i_serial_data_io_pin(st[0]),
        .i_spi_pll_off(poff), .i_spi_prediv_sel(pdiv), .i_spi_mul_sel(mul),
        .i_spi_rxdiv_sel(rxdiv), .i_spi_alt_timing(alt), .o_config_valid(seen[22]),
        .o_adc_economy(seen[21]), .o_half_duplex(seen[20]), .o_interleaved(seen[19]),
        .o_spi_enabled(seen[18]), .o_interp_code(seen[17:16]),
        .o_interp_reserved(seen[15]), .o_pll_mul(seen[14:10]), .o_pll_prediv5(seen[9]),
        .o_rx_sleep(seen[8]), .o_tx_sleep(seen[7]), .o_rx_bias_en(seen[6]),
        .o_tx_bias_en(seen[5]), .o_rx_clk_en(seen[4]), .o_tx_clk_en(seen[3]),
        .o_port_drive(seen[2]), .o_pll_run(seen[1]), .o_rx_from_pll(seen[0]),
        .o_rx_clk_tick(tick));
    // Expected outputs from captured straps and live pins
    function automatic logic [22:0] expect_of();
        logic hd, spi;
        logic [1:0] c;
        logic [4:0] m;
        hd = !cfg[4];
        spi = cfg[2];
        c = cfg[1:0];
        m = spi ? (mul <= 3'h4 ? 5'h01 << mul : 5'h01) : (c == 2'h3 ? 5'h01 : 5'h01 << c);
        return {1'b1, cfg[5], hd, hd & cfg[3], spi, c, !spi && c == 2'h3, m, spi & pdiv,
            rxpd, txpd, !rxpd, !txpd, !rxpd && !(hd && sel), !txpd && !(hd && !sel),
            hd && !sel, !(spi && poff), spi && alt && !poff};
    endfunction : expect_of
    // Expected Rx ticks over four cycles: every 1, 2 or 4 cycles while clocked
    function automatic int tick_of();
        logic [1:0] d;
        d = cfg[2] ? rxdiv : mspc_pkg::MSPC_RXDIV_1;
        if (rxpd || (!cfg[4] && sel)) return 0;
        return (d == mspc_pkg::MSPC_RXDIV_2) ? 2 : ((d == mspc_pkg::MSPC_RXDIV_4) ? 1 : 4);
    endfunction : tick_of
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic final_report();
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // Monitor takes the oldest note when a sample is flagged
    always @(negedge clk) begin
        if (win === 1'b1 && tick !== 1'b0) n_tick++;
        if (tchk === 1'b1) begin
            exp_t = qt.pop_front();
            `CHK("rx_ticks", exp_t, n_tick)
            n_tick = 0;
        end
        if (samp === 1'b1) begin
            exp_v = q.pop_front();
            `CHK("outputs", exp_v, seen)
        end
    end
    // ==========================================
    // Main sequence: capture, then power and select changes
    initial begin
        seed = $urandom(27);
        step(4);
        rst = 1'b0;
        for (int r = 0; r < 12; r++) begin
            cfg = 6'($urandom);
            if (r < 4) cfg[1:0] = 2'(r); // Every interpolation code
            rel = 1'b0;
            step(8);
            rel = 1'b1;
            for (int w = 0; w <= 20 && seen[22] !== 1'b1; w++) begin
                if (w == 20) begin
                    n_fail++;
                    final_report();
                end
                step(1);
            end
            for (int k = 0; k < 4; k++) begin
                {rxpd, txpd, sel, poff, pdiv, alt, mul, rxdiv} = 11'($urandom);
                step(5); // Pin effect lands after five edges
                win = 1'b1;
                step(2);
                q.push_back(expect_of());
                samp = 1'b1;
                step(1);
                samp = 1'b0;
                qt.push_back(tick_of());
                tchk = 1'b1;
                step(1);
                tchk = 1'b0;
                win = 1'b0;
            end
        end
        step(2);
        final_report();
    end
endmodule : tb_top
`undef CHK
`default_nettype wire
